// ### flyback_far_side.sv
// far side: thermistor, wake monitor, power stage supply
`timescale 1ns/1ns
module flyback_far_side (
	input  wire core_clk,           // clk
	input  wire pwm_enable,         // switching on
	input  wire sd_pullup_en,       // source on
	input  wire vdd_discharge_en,   // supply drain
	input  wire ntc_hot,            // thermistor hot
	input  wire load_step,          // output dip
	input  wire out_ok,             // output above enable level
	output wire sd_trip_low_cmp,    // pin tripped
	output wire sd_wake_cmp,        // pin above wake
	output reg  pwm_period_pulse,   // period start
	output wire vdd_at_reset_level  // supply drained
);
	reg [2:0] per_q = 3'h0;
	reg [4:0] dis_q = 5'h0;
	wire      wake_drv = load_step && out_ok;
	initial pwm_period_pulse = 1'b0;
	// with the source off the pin sinks to ground and reads as tripped
	assign sd_trip_low_cmp = !wake_drv && (!sd_pullup_en || ntc_hot);
	assign sd_wake_cmp = wake_drv;
	assign vdd_at_reset_level = dis_q[4];
	always @(posedge core_clk) begin
		per_q <= pwm_enable ? per_q + 3'h1 : 3'h0;
		pwm_period_pulse <= pwm_enable && per_q == 3'h7;
		dis_q <= vdd_discharge_en ? dis_q + {4'h0, !dis_q[4]} : 5'h0;
	end
endmodule

// ### flyback_fault_consts.vh
// timing constants and encodings for the flyback fault supervisor
`ifndef FLYBACK_FAULT_CONSTS_VH
`define FLYBACK_FAULT_CONSTS_VH

`define CLK_MHZ            250
`define FILT_TIME_US       125
`define FILT_CYCLES        (`FILT_TIME_US * `CLK_MHZ)
`define BROWNOUT_TIME_MS   40
`define BROWNOUT_CYCLES    (`BROWNOUT_TIME_MS * 1000 * `CLK_MHZ)
`define RESET_LONG_MS      1000
`define RESET_LONG_CYCLES  (`RESET_LONG_MS * 1000 * `CLK_MHZ)
`define RESET_SHORT_MS     100
`define RESET_SHORT_CYCLES (`RESET_SHORT_MS * 1000 * `CLK_MHZ)

`define VAR_OVLD_TIMER     2'h0
`define VAR_STANDARD       2'h1
`define VAR_LOW_OV         2'h2

`define ST_CHECK           3'h0
`define ST_RUN             3'h1
`define ST_SLEEP           3'h2
`define ST_RESTART_WAIT    3'h3
`define ST_DISCHARGE       3'h4
`define ST_LATCHED         3'h5

`endif

// ### flyback_fault_supervisor.v
// fault supervisor: filters, start-up pin checks, restart or latch, shutdown pin pull-up
//
// What this block does
// - filtered faults except brownout persist 125us and two periods
// - supply overvoltage latches only in timer variant
// - supply undervoltage always auto-restarts
// - brownout persists 40ms then auto-restarts
// - over-temperature latches only in timer variant
// - restart after cooling ten degrees below trip
// - shutdown pin low faults, variant response
// - overload fault only timer variant, auto-restart
// - output overvoltage latches only in timer variant
// - pin faults unfiltered, start-up only
// - check pins before enabling pwm
// - open (except shutdown pin), adjacent, ground, supply shorts detected
// - low-overvoltage variant: pin faults restart
// - shutdown pin at trip enters fault
// - pull shutdown pin up while running
// - drop pull-up in low-power modes
// - wake on shutdown pin rise, pulse immediately
// - auto-restart: wait, discharge, retry
// - latched: refuse restart until ac removed
`timescale 1ns/1ns
`include "flyback_fault_consts.vh"
module flyback_fault_supervisor #(
	parameter [1:0]  VARIANT      = `VAR_STANDARD,          // device variant
	parameter integer BROWNOUT_CYC = `BROWNOUT_CYCLES,      // brownout persistence
	parameter integer RST_LONG_CYC = `RESET_LONG_CYCLES,    // long restart delay
	parameter integer RST_SHRT_CYC = `RESET_SHORT_CYCLES,   // short restart delay
	parameter integer CNT_W        = 32                     // counter width
) (
	input  wire       core_clk,          // 250 MHz clock
	input  wire       rst_n,             // synchronous reset, active low
	input  wire       vdd_ov_cmp,        // supply overvoltage comparator
	input  wire       vdd_uv_cmp,        // supply undervoltage comparator
	input  wire       brownout_cmp,      // ac line low comparator
	input  wire       xcap_discharge,    // x-capacitor discharge request
	input  wire       tj_trip_cmp,       // junction over-temperature trip
	input  wire       tj_cool_cmp,       // junction 10 C below trip
	input  wire       sd_trip_low_cmp,   // fault_shutdown_pin below fault trip
	input  wire       sd_wake_cmp,       // fault_shutdown_pin above wake level
	input  wire       overload_expired,  // overload timer elapsed
	input  wire       out_ov_cmp,        // output overvoltage
	input  wire       pwm_period_pulse,  // one pulse per pwm period
	input  wire       low_power_req,     // freq below sleep_entry_freq_limit
	input  wire       pins_checked,      // start-up pin test finished
	input  wire [3:0] pin_open,          // open: sense, drive, cs, shutdown
	input  wire [3:0] pin_adj_short,     // adjacent short per pin
	input  wire [3:0] pin_gnd_short,     // ground short per pin
	input  wire [3:0] pin_vdd_short,     // supply short per pin
	input  wire       internal_diag,     // internal diagnostic fault
	input  wire       vdd_at_reset_level,// supply reached supply_reset_level
	input  wire       ac_present,        // ac input present
	output reg        pwm_enable,        // pwm allowed
	output reg        wake_pulse,        // start a pwm pulse now
	output reg        sd_pullup_en,      // shutdown pin pull-up source on
	output reg        vdd_discharge_en,  // discharge supply before retry
	output reg        hv_regulate_en,    // hold supply between latch levels
	output reg        fault_latched,     // latched fault held
	output reg        fault_restart      // auto-restart cycle active
);
	//--------------------------------------------------------------
	// input synchronisation
	//--------------------------------------------------------------
	wire [10:0] raw_in;
	wire [10:0] syn;
	assign raw_in = {vdd_ov_cmp, vdd_uv_cmp, brownout_cmp, tj_trip_cmp, tj_cool_cmp,
		sd_trip_low_cmp, sd_wake_cmp, out_ov_cmp, xcap_discharge, ac_present,
		vdd_at_reset_level};

	genvar gi;
	generate
		for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
			pin_sync u_sync (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.pin_in   (raw_in[gi]),
				.level_q  (syn[gi])
			);
		end
	endgenerate

	wire s_vdd_ov   = syn[10];
	wire s_vdd_uv   = syn[9];
	wire s_brown    = syn[8];
	wire s_tj_trip  = syn[7];
	wire s_tj_cool  = syn[6];
	wire s_sd_low   = syn[5];
	wire s_sd_wake  = syn[4];
	wire s_out_ov   = syn[3];
	wire s_xcap     = syn[2];
	wire s_ac       = syn[1];
	wire s_vdd_rst  = syn[0];

	//--------------------------------------------------------------
	// persistence filters
	//--------------------------------------------------------------
	wire [5:0] filt_in;
	wire [5:0] filt;
	// shutdown-pin trip is only meaningful while the pull-up is on
	assign filt_in = {s_vdd_ov, s_vdd_uv, s_tj_trip, s_sd_low & sd_pullup_en, s_out_ov,
		1'b0};

	generate
		for (gi = 1; gi < 6; gi = gi + 1) begin : g_filt
			persist_filter #(
				.MIN_CYCLES (`FILT_CYCLES),
				.CNT_W      (CNT_W)
			) u_filt (
				.core_clk   (core_clk),
				.rst_n      (rst_n),
				.fault_in   (filt_in[gi]),
				.pwm_edge   (pwm_period_pulse),
				.use_period (1'b1),
				.fault_q    (filt[gi])
			);
		end
	endgenerate
	assign filt[0] = 1'b0;

	wire f_brown;
	persist_filter #(
		.MIN_CYCLES (BROWNOUT_CYC),
		.CNT_W      (CNT_W)
	) u_brown (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.fault_in   (s_brown),
		.pwm_edge   (1'b0),
		.use_period (1'b0),
		.fault_q    (f_brown)
	);

	wire f_vdd_ov = filt[5];
	wire f_vdd_uv = filt[4];
	wire f_tj     = filt[3];
	wire f_sd     = filt[2];
	wire f_out_ov = filt[1];

	//--------------------------------------------------------------
	// fault classification
	//--------------------------------------------------------------
	wire is_timer = (VARIANT == `VAR_OVLD_TIMER);
	wire is_lowov = (VARIANT == `VAR_LOW_OV);

	// pin faults come straight from the start-up test, no filtering
	wire pin_fault = (|pin_open[2:0]) | (|pin_adj_short) | (|pin_gnd_short)
		| (|pin_vdd_short) | internal_diag;

	wire ovld_fault = is_timer & overload_expired;

	wire run_latch = is_timer & (f_vdd_ov | f_tj | f_sd | f_out_ov);
	wire run_auto  = f_vdd_uv | f_brown | ovld_fault
		| (!is_timer & (f_vdd_ov | f_tj | f_sd | f_out_ov));
	wire short_delay = f_brown | s_xcap;

	//--------------------------------------------------------------
	// state machine
	//--------------------------------------------------------------
	localparam [2:0] ST_CHECK = `ST_CHECK;
	localparam [2:0] ST_RUN   = `ST_RUN;
	localparam [2:0] ST_SLEEP = `ST_SLEEP;
	localparam [2:0] ST_WAIT  = `ST_RESTART_WAIT;
	localparam [2:0] ST_DISCH = `ST_DISCHARGE;
	localparam [2:0] ST_LATCH = `ST_LATCHED;

	reg [2:0]       state_q;
	reg [2:0]       state_d;
	reg [CNT_W-1:0] wait_q;
	reg [CNT_W-1:0] wait_d;
	reg             tj_hold_q;
	reg             tj_hold_d;
	reg             ac_seen_q;

	always @* begin
		state_d   = state_q;
		wait_d    = wait_q;
		tj_hold_d = tj_hold_q;
		case (state_q)
			ST_CHECK: begin
				// no pwm until the pin test is clean
				if (pins_checked) begin
					if (pin_fault && !is_lowov) begin
						state_d = ST_LATCH;
					end else if (pin_fault || run_auto || run_latch) begin
						state_d = ST_WAIT;
						wait_d  = RST_LONG_CYC[CNT_W-1:0];
					end else if (!tj_hold_q || s_tj_cool) begin
						state_d   = ST_RUN;
						tj_hold_d = 1'b0;
					end
				end
			end
			ST_RUN, ST_SLEEP: begin
				if (run_latch) begin
					state_d = ST_LATCH;
				end else if (run_auto) begin
					state_d   = ST_WAIT;
					tj_hold_d = f_tj;
					wait_d    = short_delay ? RST_SHRT_CYC[CNT_W-1:0]
						: RST_LONG_CYC[CNT_W-1:0];
				end else if (state_q == ST_RUN && low_power_req) begin
					state_d = ST_SLEEP;
				end else if (state_q == ST_SLEEP && (s_sd_wake || !low_power_req)) begin
					state_d = ST_RUN;
				end
			end
			ST_WAIT: begin
				if (wait_q == {CNT_W{1'b0}}) begin
					state_d = ST_DISCH;
				end else begin
					wait_d = wait_q - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
			ST_DISCH: begin
				if (s_vdd_rst) begin
					state_d = ST_CHECK;
				end
			end
			ST_LATCH: begin
				// only loss of ac releases the latch
				if (ac_seen_q && !s_ac) begin
					state_d   = ST_CHECK;
					tj_hold_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_CHECK;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_q          <= ST_CHECK;
			wait_q           <= {CNT_W{1'b0}};
			tj_hold_q        <= 1'b0;
			ac_seen_q        <= 1'b0;
			pwm_enable       <= 1'b0;
			wake_pulse       <= 1'b0;
			sd_pullup_en     <= 1'b0;
			vdd_discharge_en <= 1'b0;
			hv_regulate_en   <= 1'b0;
			fault_latched    <= 1'b0;
			fault_restart    <= 1'b0;
		end else begin
			state_q   <= state_d;
			wait_q    <= wait_d;
			tj_hold_q <= tj_hold_d;
			if (s_ac) begin
				ac_seen_q <= 1'b1;
			end else if (state_q == ST_LATCH) begin
				ac_seen_q <= 1'b0;
			end
			pwm_enable       <= (state_d == ST_RUN) || (state_d == ST_SLEEP);
			wake_pulse       <= (state_q == ST_SLEEP) && (state_d == ST_RUN) && s_sd_wake;
			// a wake from sleep still counts as low power until the request drops
			sd_pullup_en     <= ((state_d == ST_RUN) && !low_power_req)
				|| (state_d == ST_CHECK);
			vdd_discharge_en <= (state_d == ST_DISCH);
			hv_regulate_en   <= (state_d == ST_LATCH);
			fault_latched    <= (state_d == ST_LATCH);
			fault_restart    <= (state_d == ST_WAIT) || (state_d == ST_DISCH);
		end
	end
endmodule

// ### flyback_fault_supervisor_monitor.sv
// port checks for the fault supervisor
`timescale 1ns/1ns
module flyback_fault_supervisor_monitor #(
	parameter [1:0] VARIANT = 2'h1 // variant
) (
	input wire       core_clk,         // clk
	input wire       rst_n,            // rst
	input wire       vdd_ov_cmp,       // in
	input wire       low_power_req,    // in
	input wire       pins_checked,     // in
	input wire [3:0] pin_adj_short,    // in
	input wire [3:0] pin_gnd_short,    // in
	input wire       overload_expired, // in
	input wire       pwm_enable,       // out
	input wire       wake_pulse,       // out
	input wire       sd_pullup_en,     // out
	input wire       fault_latched,    // out
	input wire       fault_restart     // out
);
	reg [15:0] ov_cnt_q; // run length of supply overvoltage
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	always @(posedge core_clk) begin
		if (!rst_n || !vdd_ov_cmp)
			ov_cnt_q <= 16'h0;
		else if (ov_cnt_q != 16'hFFFF)
			ov_cnt_q <= ov_cnt_q + 16'h1;
	end
	a_latch_no_pwm: assert property (fault_latched |-> !pwm_enable)
		else $error("pwm on while latched");
	a_restart_no_pwm: assert property (fault_restart |-> !pwm_enable)
		else $error("pwm on in restart");
	a_wake_single: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse too long");
	a_sleep_pullup_off: assert property (low_power_req [*3] |-> !sd_pullup_en)
		else $error("pull-up on in sleep");
	a_run_pullup_on: assert property ((pwm_enable && !low_power_req) [*3] |-> sd_pullup_en)
		else $error("pull-up off in run");
	a_pin_fault_block: assert property (pins_checked && !pwm_enable
		&& (|{pin_adj_short, pin_gnd_short}) |=> !pwm_enable)
		else $error("pwm with pin fault");
	a_overload_trip: assert property (VARIANT == 2'h0 && overload_expired && pwm_enable
		|-> ##[1:4] fault_restart)
		else $error("overload not acted on");
	a_filter_hold: assert property (ov_cnt_q > 16'h0 && ov_cnt_q < 16'h7918
		&& pwm_enable |=> pwm_enable)
		else $error("fault acted on too early");
	a_filter_trip: assert property (ov_cnt_q == 16'h7A44
		|-> !pwm_enable && fault_latched == (VARIANT == 2'h0))
		else $error("supply overvoltage not acted on");
	cover property (fault_latched);
	cover property (fault_restart);
	cover property (wake_pulse);
endmodule
bind flyback_fault_supervisor flyback_fault_supervisor_monitor #(.VARIANT(VARIANT)) i_mon (
	.core_clk(core_clk), .rst_n(rst_n), .vdd_ov_cmp(vdd_ov_cmp),
	.low_power_req(low_power_req), .pins_checked(pins_checked),
	.pin_adj_short(pin_adj_short), .pin_gnd_short(pin_gnd_short),
	.overload_expired(overload_expired), .pwm_enable(pwm_enable), .wake_pulse(wake_pulse),
	.sd_pullup_en(sd_pullup_en), .fault_latched(fault_latched), .fault_restart(fault_restart)
);

// ### persist_filter.v
// persistence filter: output rises after input holds for the required time
`timescale 1ns/1ns
module persist_filter #(
	parameter integer MIN_CYCLES = 31250, // least hold time in clocks
	parameter integer CNT_W      = 32     // counter width
) (
	input  wire core_clk,   // clock
	input  wire rst_n,      // synchronous reset, active low
	input  wire fault_in,   // raw fault level
	input  wire pwm_edge,   // one-cycle pulse per pwm period start
	input  wire use_period, // also demand two pwm periods
	output reg  fault_q     // filtered fault level
);
	reg [CNT_W-1:0] cnt_q;
	reg [1:0]       per_q;
	wire            time_ok;
	wire            per_ok;

	assign time_ok = (cnt_q >= MIN_CYCLES[CNT_W-1:0]);
	assign per_ok  = !use_period || (per_q == 2'h2);

	always @(posedge core_clk) begin
		if (!rst_n || !fault_in) begin
			cnt_q   <= {CNT_W{1'b0}};
			per_q   <= 2'h0;
			fault_q <= 1'b0;
		end else begin
			if (!time_ok) begin
				cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
			if (pwm_edge && per_q != 2'h2) begin
				per_q <= per_q + 2'h1;
			end
			// the longer of the two conditions governs
			fault_q <= time_ok && per_ok;
		end
	end
endmodule

// ### pin_sync.v
// three-flop synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module pin_sync (
	input  wire core_clk, // clock
	input  wire rst_n,    // synchronous reset, active low
	input  wire pin_in,   // asynchronous pin level
	output reg  level_q   // settled level
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

// ### testbench.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ns
module testbench;
	localparam integer BRN = 50;
	localparam integer RLG = 200;
	localparam integer RSH = 50;
	reg        core_clk, rst_n, vdd_ov_cmp, brownout_cmp, overload_expired;
	reg        low_power_req, pins_checked, ac_present, load_step;
	reg        zero = 1'b0; // unexercised comparators
	reg [16:0] pv; // diag, vdd, gnd, adj, open
	integer    bad_count, n_tests, k, n;
	integer    cyc = 0;
	wire       trip, wake, per, rlev, pwm_enable, wake_pulse, sd_pullup_en;
	wire       vdd_discharge_en, fault_latched, fault_restart, hv;
	wire [3:0] obs = {wake_pulse, vdd_discharge_en, fault_restart, pwm_enable};
	flyback_fault_supervisor #(.VARIANT(2'h0), .BROWNOUT_CYC(BRN), .RST_LONG_CYC(RLG),
		.RST_SHRT_CYC(RSH)) i_flyback_fault_supervisor (.core_clk(core_clk), .rst_n(rst_n),
		.vdd_ov_cmp(vdd_ov_cmp), .vdd_uv_cmp(zero), .brownout_cmp(brownout_cmp),
		.xcap_discharge(zero), .tj_trip_cmp(zero), .tj_cool_cmp(zero), .sd_trip_low_cmp(trip),
		.sd_wake_cmp(wake), .overload_expired(overload_expired), .out_ov_cmp(zero),
		.pwm_period_pulse(per), .low_power_req(low_power_req), .pins_checked(pins_checked),
		.pin_open(pv[3:0]), .pin_adj_short(pv[7:4]), .pin_gnd_short(pv[11:8]),
		.pin_vdd_short(pv[15:12]), .internal_diag(pv[16]), .vdd_at_reset_level(rlev),
		.ac_present(ac_present), .pwm_enable(pwm_enable), .wake_pulse(wake_pulse),
		.sd_pullup_en(sd_pullup_en), .vdd_discharge_en(vdd_discharge_en), .hv_regulate_en(hv),
		.fault_latched(fault_latched), .fault_restart(fault_restart));
	flyback_far_side i_flyback_far_side (.core_clk(core_clk), .pwm_enable(pwm_enable),
		.sd_pullup_en(sd_pullup_en), .vdd_discharge_en(vdd_discharge_en), .ntc_hot(1'b0),
		.load_step(load_step), .out_ok(1'b1), .sd_trip_low_cmp(trip), .sd_wake_cmp(wake),
		.pwm_period_pulse(per), .vdd_at_reset_level(rlev));
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task tick(input integer c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task wait_bit(input integer b, input v, input integer lim);
		n = 0;
		while (obs[b] !== v && n < lim) begin
			tick(1);
			n = n + 1;
		end
	endtask
	task restart;
		rst_n = 1'b0;
		pins_checked = 1'b0;
		tick(4);
		rst_n = 1'b1;
		tick(8);
		pins_checked = 1'b1;
		tick(3);
	endtask
	task conclude;
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task t_pins;
		for (k = 0; k < 6; k = k + 1) begin
			pv = k == 0 ? 17'h00001 : k == 1 ? 17'h00020 : k == 2 ? 17'h00400 :
				k == 3 ? 17'h08000 : k == 4 ? 17'h10000 : 17'h00008;
			restart();
			tick(50);
			check("pwm_enable", pwm_enable, k == 5);
			check("fault_latched", fault_latched, k < 5);
			check("hv_regulate_en", hv, k < 5);
		end
		check("sd_pullup_en", sd_pullup_en, 1);
		pv = 17'h00040;
		restart();
		ac_present = 1'b0;
		pv = 17'h0;
		tick(10);
		ac_present = 1'b1;
		tick(10);
		check("latch after ac loss", fault_latched, 0);
	endtask
	task t_brown;
		restart();
		brownout_cmp = 1'b1;
		wait_bit(0, 1'b0, 200);
		check("brownout delay", n >= BRN && n < BRN + 40, 1);
		check("fault_restart", fault_restart, 1);
		brownout_cmp = 1'b0;
		wait_bit(2, 1'b1, RLG + 50);
		check("short delay", n >= RSH && n < RLG, 1);
		wait_bit(0, 1'b1, 200);
		check("retry", n < 200, 1);
	endtask
	task t_sleep;
		low_power_req = 1'b1;
		tick(3);
		check("sleep pull-up", sd_pullup_en, 0);
		load_step = 1'b1;
		wait_bit(3, 1'b1, 20);
		check("wake delay", n < 20, 1);
		tick(1);
		check("wake_pulse", wake_pulse, 0);
		load_step = 1'b0;
		low_power_req = 1'b0;
		overload_expired = 1'b1;
		wait_bit(1, 1'b1, 10);
		check("overload delay", n < 10, 1);
		overload_expired = 1'b0;
	endtask
	task t_ov;
		restart();
		vdd_ov_cmp = 1'b1;
		tick(31000);
		check("pwm_enable", pwm_enable, 1);
		wait_bit(0, 1'b0, 400);
		check("ov delay", n < 400, 1);
		check("fault_latched", fault_latched, 1);
		vdd_ov_cmp = 1'b0;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		bad_count = 0;
		n_tests = 0;
		{rst_n, vdd_ov_cmp, brownout_cmp, overload_expired} = 4'h0;
		{low_power_req, pins_checked, load_step} = 3'h0;
		ac_present = 1'b1;
		pv = 17'h0;
		t_pins();
		t_brown();
		t_sleep();
		t_ov();
		conclude();
	end
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			bad_count = bad_count + 1;
			conclude();
		end
	end
endmodule
